// *** pbs_regs.sv ***
// power budget data window, capability flag, record words and switch status
// assumes a single AHB-Lite master; rstn is fundamental reset, hotRstn is hot reset
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
module pbs_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hotRstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] operatingModeStrap,
    input wire logic downstreamCommonClockStrap,
    input wire logic upstreamCommonClockStrap,
    input wire logic [2:0] upstreamLockState,
    output logic systemAllocatedFlag,
    output logic dataValueWriteUnlock
);
    pbs_pkg::pbs_phase_type phase_reg;
    pbs_pkg::pbs_phase_type phase_next;
    logic [11:0] addr_reg;
    logic write_reg;
    logic [7:0] select_reg;
    logic sysAlloc_reg;
    logic regUnlock_reg;
    logic dvUnlock_reg;
    logic [3:0] marker_reg;
    logic [2:0] lock_reg;
    logic [2:0] lockSync1_reg;
    logic [2:0] lockSync2_reg;
    logic [31:0] record_reg [0:7];
    logic [31:0] rdata_reg;
    logic [4:0] straps;
    logic [31:0] windowData;
    logic [31:0] statusWord;
    logic [31:0] readMux;
    logic addrPhase;
    logic wrData;
    logic hitSelect;
    logic hitCapability;
    logic hitStatus;
    logic hitControl;
    logic hitValues;
    logic [2:0] valueIndex;
    logic [2:0] lockNext;
    logic readAfterWrite;

    // straps captured while fundamental reset is asserted
    pbs_strap_sync u_straps (
        .clock(clock),
        .rstn(1'b1),
        .fundRstn(rstn),
        .pinIn({upstreamCommonClockStrap, downstreamCommonClockStrap, operatingModeStrap}),
        .captured(straps)
    );

    // lock state from the port logic crosses two flops before use
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lockSync1_reg <= 3'h0;
            lockSync2_reg <= 3'h0;
            lock_reg <= 3'h0;
        end else begin
            lockSync1_reg <= upstreamLockState;
            lockSync2_reg <= lockSync1_reg;
            lock_reg <= lockNext;
        end
    end
    // codes above five are not defined lock states, shown as unlocked
    assign lockNext = (lockSync2_reg > pbs_pkg::LOCK_MAX) ? 3'h0 : lockSync2_reg;

    // bus decode; one wait state only for a read right behind a write, always OKAY
    assign addrPhase = hsel && htrans[1] && hready;
    assign phase_next = addrPhase ? pbs_pkg::PBS_DATA : pbs_pkg::PBS_IDLE;
    assign wrData = (phase_reg == pbs_pkg::PBS_DATA) && write_reg;
    assign hitSelect = addr_reg == pbs_pkg::SELECT_OFFSET;
    assign hitCapability = addr_reg == pbs_pkg::CAPABILITY_OFFSET;
    assign hitStatus = addr_reg == pbs_pkg::STATUS_OFFSET;
    assign hitControl = addr_reg == pbs_pkg::CONTROL_OFFSET;
    assign hitValues = addr_reg[11:5] == pbs_pkg::VALUES_OFFSET[11:5];
    assign valueIndex = addr_reg[4:2];
    // read data is taken in the address phase, so a read behind a write would see the
    // old value; holding the read one cycle lets the write land first
    assign readAfterWrite = wrData && hsel && htrans[1] && !hwrite;
    assign hreadyout = !readAfterWrite;
    assign hresp = 1'b0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= pbs_pkg::PBS_IDLE;
            addr_reg <= 12'h000;
            write_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            addr_reg <= addrPhase ? haddr[11:0] : addr_reg;
            write_reg <= addrPhase && hwrite;
        end
    end

    // select register: upper bits are not stored at all
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            select_reg <= pbs_pkg::SELECT_RESET;
        end else if (wrData && hitSelect) begin
            select_reg <= hwdata[pbs_pkg::SELECT_MSB:0];
        end
    end

    // unlock bits are sticky: hot reset never clears them; fundamental reset or a control write of zero while register unlock is set does
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regUnlock_reg <= 1'b0;
            dvUnlock_reg <= 1'b0;
        end else if (wrData && hitControl) begin
            regUnlock_reg <= hwdata[pbs_pkg::REG_UNLOCK_BIT];
            if (regUnlock_reg) begin
                dvUnlock_reg <= hwdata[pbs_pkg::DV_UNLOCK_BIT];
            end
        end
    end

    // allocated flag; a loader sets it through the same unlocked path
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sysAlloc_reg <= 1'b0;
        end else if (wrData && hitCapability && regUnlock_reg) begin
            sysAlloc_reg <= hwdata[pbs_pkg::SYS_ALLOC_BIT];
        end
    end

    // marker survives hot reset since hotRstn never reaches it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            marker_reg <= pbs_pkg::MARKER_RESET;
        end else if (wrData && hitStatus) begin
            marker_reg <= hwdata[31:pbs_pkg::MARKER_LSB];
        end
    end

    // record words: no reset so contents persist (sticky, undefined at power-up)
    genvar gi;
    generate
        for (gi = 0; gi < pbs_pkg::RECORD_COUNT; gi++) begin : g_rec
            always_ff @(posedge clock) begin
                if (wrData && hitValues && dvUnlock_reg && valueIndex == 3'(gi)) begin
                    record_reg[gi] <= hwdata;
                end
            end
        end
    endgenerate

    // window returns zero for selects past the last record
    assign windowData = (select_reg < 8'(pbs_pkg::RECORD_COUNT))
        ? record_reg[select_reg[2:0]] : 32'h0000_0000;
    assign statusWord = {marker_reg, 5'h00, lock_reg, 13'h0000, straps[4], straps[3],
        2'h0, straps[2:0]};

    // read mux; unmapped offsets read zero
    always_comb begin
        readMux = 32'h0000_0000;
        if (haddr[11:0] == pbs_pkg::SELECT_OFFSET) begin
            readMux = {24'h000000, select_reg};
        end else if (haddr[11:0] == pbs_pkg::WINDOW_OFFSET) begin
            readMux = windowData;
        end else if (haddr[11:0] == pbs_pkg::CAPABILITY_OFFSET) begin
            readMux = {31'h0000_0000, sysAlloc_reg};
        end else if (haddr[11:5] == pbs_pkg::VALUES_OFFSET[11:5]) begin
            readMux = record_reg[haddr[4:2]];
        end else if (haddr[11:0] == pbs_pkg::STATUS_OFFSET) begin
            readMux = statusWord;
        end else if (haddr[11:0] == pbs_pkg::CONTROL_OFFSET) begin
            readMux = {27'h0000000, dvUnlock_reg, regUnlock_reg, 3'h0};
        end
    end

    // read data registered in the address phase, stands during data phase
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            rdata_reg <= readMux;
        end
    end
    assign hrdata = rdata_reg;
    assign systemAllocatedFlag = sysAlloc_reg;
    assign dataValueWriteUnlock = dvUnlock_reg;

    // hot reset reaches no field here; the first assertion below watches that
    property p_hot_keep;
        @(posedge clock) disable iff (!rstn)
        (!hotRstn && !wrData) |=> $stable(marker_reg) && $stable(regUnlock_reg)
            && $stable(dvUnlock_reg) && $stable(sysAlloc_reg);
    endproperty
    a_hot_keep: assert property (p_hot_keep) else $error("sticky lost");

    property p_window_zero;
        @(posedge clock) disable iff (!rstn)
        (addrPhase && !hwrite && haddr[11:0] == pbs_pkg::WINDOW_OFFSET && select_reg > 8'h07)
            |=> hrdata == 32'h0000_0000;
    endproperty
    a_window_zero: assert property (p_window_zero) else $error("window not zero");

    property p_window_sel;
        @(posedge clock) disable iff (!rstn)
        (addrPhase && !hwrite && haddr[11:0] == pbs_pkg::WINDOW_OFFSET && select_reg < 8'h08)
            |=> hrdata == $past(record_reg[select_reg[2:0]]);
    endproperty
    a_window_sel: assert property (p_window_sel) else $error("window wrong word");

    property p_select_write;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitSelect) |=> select_reg == $past(hwdata[7:0]);
    endproperty
    a_select_write: assert property (p_select_write) else $error("select not stored");

    property p_select_high;
        @(posedge clock) disable iff (!rstn)
        (addrPhase && !hwrite && haddr[11:0] == pbs_pkg::SELECT_OFFSET)
            |=> hrdata[31:8] == 24'h000000;
    endproperty
    a_select_high: assert property (p_select_high) else $error("select upper set");

    property p_dv_locked;
        @(posedge clock) disable iff (!rstn)
        !regUnlock_reg |=> $stable(dvUnlock_reg);
    endproperty
    a_dv_locked: assert property (p_dv_locked) else $error("unlock changed locked");

    property p_dv_write;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitControl && regUnlock_reg) |=> dvUnlock_reg == $past(hwdata[4]);
    endproperty
    a_dv_write: assert property (p_dv_write) else $error("unlock not written");

    property p_alloc_locked;
        @(posedge clock) disable iff (!rstn)
        !regUnlock_reg |=> $stable(sysAlloc_reg);
    endproperty
    a_alloc_locked: assert property (p_alloc_locked) else $error("flag changed locked");

    property p_alloc_write;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitCapability && regUnlock_reg) |=> sysAlloc_reg == $past(hwdata[0]);
    endproperty
    a_alloc_write: assert property (p_alloc_write) else $error("flag not written");

    property p_rec_locked;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitValues && !dvUnlock_reg) |=> record_reg[$past(valueIndex)]
            == $past(record_reg[valueIndex]);
    endproperty
    a_rec_locked: assert property (p_rec_locked) else $error("record written locked");

    property p_rec_write;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitValues && dvUnlock_reg) |=> record_reg[$past(valueIndex)] == $past(hwdata);
    endproperty
    a_rec_write: assert property (p_rec_write) else $error("record not written");

    property p_status_bits;
        @(posedge clock) disable iff (!rstn)
        (addrPhase && !hwrite && haddr[11:0] == pbs_pkg::STATUS_OFFSET)
            |=> hrdata[2:0] == $past(straps[2:0]) && hrdata[4:3] == 2'h0
            && hrdata[5] == $past(straps[3]) && hrdata[6] == $past(straps[4])
            && hrdata[19:7] == 13'h0000 && hrdata[22:20] == $past(lock_reg)
            && hrdata[27:23] == 5'h00 && hrdata[31:28] == $past(marker_reg);
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status layout");

    property p_lock_range;
        @(posedge clock) disable iff (!rstn)
        lock_reg <= 3'h5;
    endproperty
    a_lock_range: assert property (p_lock_range) else $error("lock code out of range");

    property p_lock_follow;
        @(posedge clock) disable iff (!rstn)
        (lockSync2_reg <= pbs_pkg::LOCK_MAX) |=> lock_reg == $past(lockSync2_reg);
    endproperty
    a_lock_follow: assert property (p_lock_follow) else $error("lock not shown");

    property p_marker_hold;
        @(posedge clock) disable iff (!rstn)
        !(wrData && hitStatus) |=> $stable(marker_reg);
    endproperty
    a_marker_hold: assert property (p_marker_hold) else $error("marker changed");

    property p_marker_write;
        @(posedge clock) disable iff (!rstn)
        (wrData && hitStatus) |=> marker_reg == $past(hwdata[31:28]);
    endproperty
    a_marker_write: assert property (p_marker_write) else $error("marker lost");

    property p_cap_zero;
        @(posedge clock) disable iff (!rstn)
        (addrPhase && !hwrite && haddr[11:0] == 12'h28c) |=> rdata_reg[31:1] == 31'h0;
    endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("reserved nonzero");

    c_rec_write: cover property (@(posedge clock) disable iff (!rstn)
        wrData && hitValues && dvUnlock_reg);
    c_window_hi: cover property (@(posedge clock) disable iff (!rstn) select_reg > 8'h07);
    c_alloc_set: cover property (@(posedge clock) disable iff (!rstn) $rose(sysAlloc_reg));
    c_locked: cover property (@(posedge clock) disable iff (!rstn) lock_reg == 3'h5);
    c_hot_keep: cover property (@(posedge clock) disable iff (!rstn) !hotRstn && marker_reg != 4'h0);
endmodule // pbs_regs

// *** pbs_pkg.sv ***
// package for the power budget / switch status register bank
// assumes one 100 MHz clock, AHB-Lite register access, 32-bit word registers
// Operation
// - budget data window returns selected word, else zero
// - select register: index bits 7:0, reset zero
// - capability bit 0 is system allocated flag
// - unlockable fields writable only while unlock set
// - eight sticky record words at 0x300-0x31c
// - record word writes need data-value unlock set
// - data-value unlock is sticky control bit 4
// - status bits 2:0 show mode pins captured at reset
// - status bit 5: downstream clock strap at reset
// - status bit 6: upstream clock strap at reset
// - status bits 22:20 report upstream lock state
// - status bits 31:28 sticky software marker field
package pbs_pkg;
    localparam logic [11:0] SELECT_OFFSET = 12'h284;
    localparam logic [11:0] WINDOW_OFFSET = 12'h288;
    localparam logic [11:0] CAPABILITY_OFFSET = 12'h28c;
    localparam logic [11:0] VALUES_OFFSET = 12'h300;
    localparam logic [11:0] STATUS_OFFSET = 12'h400;
    localparam logic [11:0] CONTROL_OFFSET = 12'h404;
    localparam int RECORD_COUNT = 8;
    localparam int SELECT_MSB = 7;
    localparam int SYS_ALLOC_BIT = 0;
    localparam int REG_UNLOCK_BIT = 3;
    localparam int DV_UNLOCK_BIT = 4;
    localparam int MODE_LSB = 0;
    localparam int DS_CLOCK_BIT = 5;
    localparam int US_CLOCK_BIT = 6;
    localparam int LOCK_LSB = 20;
    localparam int MARKER_LSB = 28;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [3:0] MARKER_RESET = 4'h0;
    localparam logic [2:0] LOCK_MAX = 3'h5;
    localparam logic [31:0] RECORD_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        PBS_IDLE = 2'b01,
        PBS_DATA = 2'b10
    } pbs_phase_type;
endpackage

// *** pbs_strap_sync.sv ***
// two-flop synchroniser plus capture of straps while fundamental reset is low
// assumes straps are stable around the release of fundamental reset
`timescale 1ns/1ns
module pbs_strap_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic fundRstn,
    input wire logic [4:0] pinIn,
    output logic [4:0] captured
);
    logic [4:0] stage1_reg;
    logic [4:0] stage2_reg;
    logic fundSync1_reg;
    logic fundSync2_reg;
    logic [4:0] captured_reg;
    logic [4:0] captured_next;

    // stage1 is read only by stage2
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= 5'h00;
            stage2_reg <= 5'h00;
            fundSync1_reg <= 1'b0;
            fundSync2_reg <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            fundSync1_reg <= fundRstn;
            fundSync2_reg <= fundSync1_reg;
        end
    end

    // keep tracking during fundamental reset, freeze once it releases
    assign captured_next = fundSync2_reg ? captured_reg : stage2_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            captured_reg <= 5'h00;
        end else begin
            captured_reg <= captured_next;
        end
    end
    assign captured = captured_reg;
endmodule // pbs_strap_sync

// *** tb_power_budget_switch_status_regs.sv ***
// self-checking bench for the power budget window, capability flag, records and switch status
// assumes pbs_regs answers through hready (a read behind a write may wait) and hrdata in data phase
`timescale 1ns/1ns
module tb_power_budget_switch_status_regs;
    logic clock;
    logic rstn;
    logic hotRstn;
    logic hsel;
    logic hwrite;
    logic hreadyout;
    logic hresp;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [2:0] modeStrap;
    logic [2:0] lockState;
    logic dsStrap;
    logic usStrap;
    logic sysFlag;
    logic dvUnlock;
    logic rdPhase = 1'b0;
    logic [31:0] recVal [8];
    logic [31:0] expQ [$];
    logic [31:0] sel;
    int failures;
    int cmpCount;
    wire hready = hreadyout;

    pbs_regs dut (.clock(clock), .rstn(rstn), .hotRstn(hotRstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .operatingModeStrap(modeStrap),
        .downstreamCommonClockStrap(dsStrap), .upstreamCommonClockStrap(usStrap),
        .upstreamLockState(lockState), .systemAllocatedFlag(sysFlag),
        .dataValueWriteUnlock(dvUnlock));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // watcher: every finished read data phase takes the oldest expectation
    always @(posedge clock) begin
        if (rdPhase && hready) begin
            if (expQ.size() == 0) begin
                failures++;
                $display("BAD at %0t got %h expected %h", $time, hrdata, 32'h0000_0000);
            end else begin
                cmp_word(hrdata, expQ.pop_front());
            end
        end
        if (hready) begin
            rdPhase <= hsel && htrans[1] && !hwrite;
        end
    end

    // bounded wait for hready at a rising edge; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            failures++;
            close_out();
        end
    endtask

    // one single word transfer; called right after a rising edge
    task automatic xfer(input logic isWrite, input logic [31:0] addr, input logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= isWrite;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= data;
        wait_ready();
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        xfer(1'b1, addr, data);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        expQ.push_back(exp);
        xfer(1'b0, addr, 32'h0000_0000);
    endtask

    // flags are sampled mid-cycle so the updating edge has landed
    task automatic flags(input logic expSys, input logic expDv);
        @(negedge clock);
        cmp_flag(sysFlag, expSys);
        cmp_flag(dvUnlock, expDv);
        @(posedge clock);
    endtask

    // straps flip after release: the captured values must not follow them
    task automatic fund_reset(input logic [2:0] m, input logic ds, input logic us);
        rstn <= 1'b0;
        modeStrap <= m;
        dsStrap <= ds;
        usStrap <= us;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (5) @(posedge clock);
        modeStrap <= ~m;
        dsStrap <= ~ds;
        usStrap <= ~us;
    endtask

    function automatic logic [31:0] sts(logic [3:0] mk, logic [2:0] lk, logic us, logic ds,
        logic [2:0] m);
        return {mk, 5'h00, lk, 13'h0000, us, ds, 2'b00, m};
    endfunction

    initial begin
        rstn = 1'b0;
        hotRstn = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        modeStrap = 3'h1;
        dsStrap = 1'b1;
        usStrap = 1'b0;
        lockState = 3'h0;
        failures = 0;
        cmpCount = 0;
        void'($urandom(17900));
        fund_reset(3'h1, 1'b1, 1'b0);
        rd(32'h0000_0284, 32'h0000_0000);
        rd(32'h0000_028c, 32'h0000_0000);
        rd(32'h0000_0400, sts(4'h0, 3'h0, 1'b0, 1'b1, 3'h1));
        // still locked: flag and data-value unlock refuse writes
        wr(32'h0000_028c, 32'hffff_ffff);
        wr(32'h0000_0404, 32'h0000_0010);
        rd(32'h0000_028c, 32'h0000_0000);
        rd(32'h0000_0404, 32'h0000_0000);
        wr(32'h0000_0404, 32'h0000_0008);
        wr(32'h0000_0404, 32'h0000_0018);
        rd(32'h0000_0404, 32'h0000_0018);
        wr(32'h0000_028c, 32'hffff_ffff);
        rd(32'h0000_028c, 32'h0000_0001);
        flags(1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            recVal[i] = $urandom;
            wr(32'h0000_0300 + 32'(4 * i), recVal[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(32'h0000_0300 + 32'(4 * i), recVal[i]);
            wr(32'h0000_0284, 32'(i));
            rd(32'h0000_0288, recVal[i]);
        end
        wr(32'h0000_0284, 32'hffff_ff08);
        rd(32'h0000_0284, 32'h0000_0008);
        rd(32'h0000_0288, 32'h0000_0000);
        // random selects mix in-range and out-of-range indices
        for (int i = 0; i < 8; i++) begin
            sel = 32'($urandom_range(0, 15)) | ((i == 7) ? 32'h0000_00ff : 32'h0);
            wr(32'h0000_0284, sel);
            rd(32'h0000_0288, (sel < 8) ? recVal[sel[2:0]] : 32'h0000_0000);
        end
        // drop the data-value unlock, keep the register unlock
        wr(32'h0000_0404, 32'h0000_0008);
        flags(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(32'h0000_0300 + 32'(4 * i), ~recVal[i]);
            rd(32'h0000_0300 + 32'(4 * i), recVal[i]);
        end
        for (int k = 0; k < 8; k++) begin
            lockState <= 3'(k);
            repeat (5) @(posedge clock);
            rd(32'h0000_0400, sts(4'h0, (k <= 5) ? 3'(k) : 3'h0, 1'b0, 1'b1, 3'h1));
        end
        lockState <= 3'h0;
        wr(32'h0000_0400, 32'hffff_ffff);
        rd(32'h0000_0400, sts(4'hf, 3'h0, 1'b0, 1'b1, 3'h1));
        // hot reset leaves sticky state alone
        hotRstn <= 1'b0;
        repeat (3) @(posedge clock);
        hotRstn <= 1'b1;
        @(posedge clock);
        rd(32'h0000_0400, sts(4'hf, 3'h0, 1'b0, 1'b1, 3'h1));
        rd(32'h0000_0404, 32'h0000_0008);
        rd(32'h0000_0300, recVal[0]);
        wr(32'h0000_0500, 32'hffff_ffff);
        rd(32'h0000_0500, 32'h0000_0000);
        fund_reset(3'h0, 1'b0, 1'b1);
        rd(32'h0000_0400, sts(4'h0, 3'h0, 1'b1, 1'b0, 3'h0));
        rd(32'h0000_028c, 32'h0000_0000);
        flags(1'b0, 1'b0);
        repeat (2) @(posedge clock);
        if (expQ.size() != 0) begin
            failures++;
        end
        close_out();
    end
endmodule // tb_power_budget_switch_status_regs
